// *** test_timing_pulse_clock_output.sv ***
/*
 * Self-checking bench for the timing pulse and aligned clock block.
 * Assumes tpc_top, tpc_far_end and the bound checker are compiled first.
 */
`timescale 1ns/100ps
module test_timing_pulse_clock_output;
  localparam TICK = 5000;
  logic        mclk, rst, supply_good, pull_rst, strap, oe_n, ext_n;
  logic        cpu_reset, low_gain, tick, pulse, aclk, rxd, txd, irq;
  logic        a0, a1, rerr, eb, wreq, rd_en, wr_en;
  logic [1:0]  ant;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, rd;
  int          num_errors, compares, n;
  // Timing outputs only observed, nothing pulls them up
  tpc_top #(.POR_CYC(100)) i_dut (
    .mclk(mclk), .rst(rst), .supply_good(supply_good),
    .ext_reset_n_in(ext_n), .ext_reset_n_out(), .ext_reset_n_oe_n(oe_n),
    .cpu_reset(cpu_reset), .gain_select_strap(strap),
    .antenna_status_0(a0), .antenna_status_1(a1), .low_gain_ff(low_gain),
    .time_tick(tick), .timing_pulse_out(pulse), .aligned_clock_out(aclk),
    .serial_rx_in(rxd), .serial_tx_out(txd), .avs_address(addr),
    .avs_read(rd_en), .avs_write(wr_en), .avs_writedata(wdata),
    .avs_byteenable(4'hF), .avs_readdata(rdata),
    .avs_waitrequest(wreq), .avs_response_err(rerr), .irq(irq));
  // Far end: ticks, detector, reset pin, commands
  tpc_far_end #(.TICK(TICK), .BIT(16)) i_far (
    .mclk(mclk), .pull_rst(pull_rst), .ant_sel(ant),
    .ext_reset_n_oe_n(oe_n), .ext_reset_n_in(ext_n),
    .antenna_status_0(a0), .antenna_status_1(a1),
    .time_tick(tick), .serial_rx_in(rxd));
  // Clock at 125 MHz
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // Compare and count
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Verdict and end of run
  task end_sim;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // One bus transfer, held until waitrequest is low
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    rd_en <= !w;
    wr_en <= w;
    addr <= a;
    wdata <= d;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (wreq !== 1'b0 && k < 50);
    if (k >= 50) begin
      num_errors++;
      end_sim;
    end
    rd = rdata;
    eb = rerr;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
  endtask
  // Wait for a rise of pulse (s low) or clock (s high)
  task wrise(input logic s, input int lim);
    n = 0;
    while ((s ? aclk : pulse) !== 1'b0 && n < lim) begin
      @(negedge mclk);
      n++;
    end
    while ((s ? aclk : pulse) !== 1'b1 && n < lim) begin
      @(negedge mclk);
      n++;
    end
  endtask
  // Wait for module reset to drop
  task wrst;
    n = 0;
    while (cpu_reset !== 1'b0 && n < 400) begin
      @(negedge mclk);
      n++;
    end
  endtask
  // Power-on release and reset levels
  task t_por;
    wrst;
    chk("por_time", n >= 100 && n <= 112, 1'b1);
    chk("tx_idle", txd, 1'b1);
    chk("low_gain", low_gain, 1'b1);
    $display("done por");
  endtask
  // Reset values, unmapped place, strap bit
  task t_regs;
    logic [7:0]  ad [4] = '{8'h04, 8'h08, 8'h14, 8'h1C};
    logic [31:0] ex [4] = '{32'h0000_0001, 32'h0000_0FA0,
                            32'h0000_0000, 32'h0000_0CB7};
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, ad[i], 32'h0);
      chk("reset_value", rd, ex[i]);
    end
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped", rd, 32'hDEAD_0BAD);
    chk("resp_err", eb, 1'b1);
    bus(1'b0, 8'h0C, 32'h0);
    chk("gain_bit", rd[3], 1'b1);
    $display("done regs");
  endtask
  // Every antenna state and its event
  task t_ant;
    logic [1:0] st [3] = '{2'b10, 2'b01, 2'b11};
    for (int i = 0; i < 3; i++) begin
      ant <= st[i];
      repeat (4) @(posedge mclk);
      bus(1'b0, 8'h0C, 32'h0);
      chk("ant_state", rd[1:0], st[i]);
      bus(1'b0, 8'h10, 32'h0);
      chk("ant_event", rd[1], 1'b1);
      bus(1'b1, 8'h10, 32'h0000_0002);
    end
    $display("done ant");
  endtask
  // Clock at 40 kHz, out of range, back to 4 kHz
  task t_clk;
    bus(1'b1, 8'h08, 32'h0000_9C40);
    bus(1'b1, 8'h00, 32'h0000_0001);
    wrise(1'b0, 3 * TICK);
    chk("clk_with_pulse", aclk, 1'b1);
    chk("pulse_on_tick", i_far.cnt_ff <= 2, 1'b1);
    wrise(1'b1, 4000);
    chk("clk_period", n, 32'h0000_0C35);
    bus(1'b1, 8'h08, 32'h0000_0F9F);
    wrise(1'b1, 2 * TICK);
    chk("clk_stopped", n, 2 * TICK);
    chk("clk_low", aclk, 1'b0);
    bus(1'b1, 8'h08, 32'h0000_0FA0);
    wrise(1'b0, 3 * TICK);
    chk("run_at_min", pulse, 1'b1);
    $display("done clk");
  endtask
  // Serial divisor command, bad selector and interrupt
  task t_ser;
    logic [7:0] cmd [5] = '{8'h01, 8'h02, 8'h00, 8'h00, 8'h00};
    bus(1'b1, 8'h1C, 32'h0000_0010);
    foreach (cmd[i]) i_far.send(cmd[i]);
    bus(1'b0, 8'h04, 32'h0);
    chk("pulse_div", rd, 32'h0000_0002);
    wrise(1'b0, 3 * TICK);
    wrise(1'b0, 3 * TICK);
    chk("pulse_gap", n, 2 * TICK);
    bus(1'b1, 8'h14, 32'h0);
    bus(1'b1, 8'h10, 32'h0000_000F);
    for (int i = 0; i < 5; i++) i_far.send(i == 0 ? 8'h03 : 8'h00);
    bus(1'b0, 8'h10, 32'h0);
    chk("bad_cmd", rd[3], 1'b1);
    chk("irq_masked", irq, 1'b0);
    bus(1'b1, 8'h14, 32'h0000_0008);
    @(negedge mclk);
    chk("irq_on", irq, 1'b1);
    bus(1'b1, 8'h10, 32'h0000_0008);
    @(negedge mclk);
    chk("irq_off", irq, 1'b0);
    $display("done ser");
  endtask
  // External reset, strap low, supply dip
  task t_ext;
    @(posedge mclk);
    strap <= 1'b0;
    pull_rst <= 1'b1;
    repeat (8) @(negedge mclk);
    chk("ext_reset", cpu_reset, 1'b1);
    chk("quiet", pulse | aclk, 1'b0);
    @(posedge mclk);
    pull_rst <= 1'b0;
    wrst;
    chk("ext_release", n < 20, 1'b1);
    chk("high_gain", low_gain, 1'b0);
    @(posedge mclk);
    supply_good <= 1'b0;
    repeat (8) @(negedge mclk);
    chk("por_on_dip", oe_n, 1'b0);
    chk("pin_pulled", ext_n, 1'b0);
    @(posedge mclk);
    supply_good <= 1'b1;
    wrst;
    chk("por_again", n >= 100 && n <= 112, 1'b1);
    $display("done ext");
  endtask
  // Main sequence
  initial begin
    rst = 1'b1;
    supply_good = 1'b1;
    strap = 1'b1; // Tied to supply, active antenna
    pull_rst = 1'b0;
    ant = 2'b11;
    rd_en = 1'b0;
    wr_en = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    t_por;
    t_regs;
    t_ant;
    t_clk;
    t_ser;
    t_ext;
    end_sim;
  end
endmodule

// *** tpc_far_end.sv ***
/*
 * Far end: time-scale ticks, antenna detector, reset pin, command sender.
 * Assumes send is called just after a rising edge of mclk.
 */
`timescale 1ns/100ps
module tpc_far_end #(
  parameter TICK = 5000,
  parameter BIT  = 16
) (
  // Clock and controls
  input  wire        mclk,
  input  wire        pull_rst,
  input  wire  [1:0] ant_sel,
  // Device side
  input  wire        ext_reset_n_oe_n,
  output wire        ext_reset_n_in,
  output wire        antenna_status_0,
  output wire        antenna_status_1,
  output logic       time_tick,
  output logic       serial_rx_in
);
  int cnt_ff;
  // Open-drain on both sides, pull-up wins when released
  // Reserved pins are not modelled and stay open
  assign ext_reset_n_in = (pull_rst || !ext_reset_n_oe_n) ?
                          1'b0 : 1'b1;
  // Detector reports normal, open or short
  assign antenna_status_0 = ant_sel[0];
  assign antenna_status_1 = ant_sel[1];
  // Line idles high
  initial begin
    cnt_ff = 0;
    time_tick = 1'b0;
    serial_rx_in = 1'b1;
  end
  // One-cycle tick every TICK cycles
  always @(posedge mclk) begin
    cnt_ff <= (cnt_ff == TICK - 1) ? 0 : cnt_ff + 1;
    time_tick <= (cnt_ff == TICK - 1);
  end
  // Command byte, start bit, LSB first, stop bit
  task send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      serial_rx_in <= f[i];
      repeat (BIT) @(posedge mclk);
    end
  endtask
endmodule

// *** tpc_map.vh ***
/*
 * Register map, field positions, reset values and timing constants of the
 * timing pulse and aligned clock block.
 * Assumes a 125 MHz core clock and a 32-bit Avalon-MM slave port.
 */
`ifndef TPC_MAP_VH
`define TPC_MAP_VH

// Register byte addresses
`define TPC_REG_CTRL      8'h00
`define TPC_REG_PULSE_DIV 8'h04
`define TPC_REG_CLK_FREQ  8'h08
`define TPC_REG_STATUS    8'h0C
`define TPC_REG_IRQ_STAT  8'h10
`define TPC_REG_IRQ_MASK  8'h14
`define TPC_REG_PINS      8'h18
`define TPC_REG_BAUD_DIV  8'h1C

// Control fields
`define TPC_CTRL_EN       0
`define TPC_CTRL_SWRST    1

// Interrupt status bits
`define TPC_IRQ_PULSE     0
`define TPC_IRQ_ANT       1
`define TPC_IRQ_RX        2
`define TPC_IRQ_CFGERR    3
`define TPC_IRQ_W         4

// Antenna states on the two pulled-up inputs
`define TPC_ANT_NORMAL    2'b11
`define TPC_ANT_OPEN      2'b10
`define TPC_ANT_SHORT     2'b01

// Aligned clock frequency limits in Hz
`define TPC_CLK_MIN_HZ    32'h0000_0FA0
`define TPC_CLK_MAX_HZ    32'h0000_9C40

// Core clock rate and serial defaults
`define TPC_MCLK_HZ       32'h0773_5940
`define TPC_BAUD_DEF      32'h0000_9600
`define TPC_PULSE_DIV_DEF 32'h0000_0001

// Power-on reset release window in ms
`define TPC_POR_MIN_MS    32'h0000_0096
`define TPC_POR_MAX_MS    32'h0000_00FA

// Serial command selectors
`define TPC_CMD_PDIV      8'h01
`define TPC_CMD_CFRQ      8'h02

// Unmapped read answer
`define TPC_BAD_DATA      32'hDEAD_0BAD

`endif

// *** tpc_properties.sv ***
/*
 * Port checker for the timing pulse block.
 * Assumes one mclk domain with rst async active high.
 */
`timescale 1ns/100ps
module tpc_chk #(
  parameter POR_CYC = 32'd18750000
) (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Reset sources and strap
  input wire supply_good,
  input wire ext_reset_n_in,
  input wire ext_reset_n_oe_n,
  input wire cpu_reset,
  input wire gain_select_strap,
  input wire low_gain_ff,
  // Outputs and bus
  input wire timing_pulse_out,
  input wire aligned_clock_out,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest
);
  logic [31:0] sup_cnt_ff;
  logic [31:0] nxt_sup_cnt;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Run length of good supply
  assign nxt_sup_cnt = supply_good ? sup_cnt_ff + 32'h1 : 32'h0;
  always @(posedge mclk or posedge rst) begin
    if (rst)
      sup_cnt_ff <= 32'h0;
    else
      sup_cnt_ff <= nxt_sup_cnt;
  end
  property p_por_min; $rose(ext_reset_n_oe_n) |-> sup_cnt_ff >= POR_CYC;
  endproperty
  a_por_min: assert property (p_por_min)
    else $error("power-on release too early");
  property p_por_max; sup_cnt_ff > POR_CYC + 8 |-> ext_reset_n_oe_n;
  endproperty
  a_por_max: assert property (p_por_max)
    else $error("power-on release too late");
  property p_sup; !supply_good [*4] |-> !ext_reset_n_oe_n;
  endproperty
  a_sup: assert property (p_sup)
    else $error("low supply without power-on reset");
  property p_ext; !ext_reset_n_in [*4] |-> cpu_reset;
  endproperty
  a_ext: assert property (p_ext)
    else $error("pin low without module reset");
  property p_gain; (cpu_reset && gain_select_strap) [*6] |-> low_gain_ff;
  endproperty
  a_gain: assert property (p_gain)
    else $error("strap high not taken as low gain");
  property p_quiet;
    cpu_reset [*3] |-> !timing_pulse_out && !aligned_clock_out;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("outputs active in reset");
  property p_align; $rose(timing_pulse_out) |-> $rose(aligned_clock_out);
  endproperty
  a_align: assert property (p_align)
    else $error("pulse rose without clock rise");
  property p_ack; avs_read || avs_write |-> ##[0:1] !avs_waitrequest;
  endproperty
  a_ack: assert property (p_ack)
    else $error("bus answer late");
endmodule
bind tpc_top tpc_chk #(.POR_CYC(POR_CYC)) i_chk (
  .mclk(mclk), .rst(rst), .supply_good(supply_good),
  .ext_reset_n_in(ext_reset_n_in), .ext_reset_n_oe_n(ext_reset_n_oe_n),
  .cpu_reset(cpu_reset), .gain_select_strap(gain_select_strap),
  .low_gain_ff(low_gain_ff), .timing_pulse_out(timing_pulse_out),
  .aligned_clock_out(aligned_clock_out), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest));

// *** tpc_rx_shift.v ***
/*
 * Serial reception shifter: takes synchronised 8N1 frames at a programmable
 * bit period and presents each byte for one cycle.
 * Assumes the serial input has already passed two flip-flops.
 */
`timescale 1ns/100ps
module tpc_rx_shift #(
  parameter DIV_W = 16
) (
  // Clock and reset
  input  wire             mclk,
  input  wire             rst,
  // Bit period in core cycles
  input  wire [DIV_W-1:0] bit_div,
  // Synchronised line
  input  wire             rx_sync,
  // Received byte
  output reg  [7:0]       rx_data_ff,
  output reg              rx_valid_ff
);
  reg [DIV_W-1:0] cnt_ff;
  reg [3:0]       bit_ff;
  reg             busy_ff;
  reg [7:0]       sh_ff;

  // Frame capture, sampling mid-bit
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_ff      <= {DIV_W{1'b0}};
      bit_ff      <= 4'h0;
      busy_ff     <= 1'b0;
      sh_ff       <= 8'h00;
      rx_data_ff  <= 8'h00;
      rx_valid_ff <= 1'b0;
    end else begin
      rx_valid_ff <= 1'b0;
      if (!busy_ff) begin
        if (!rx_sync) begin
          busy_ff <= 1'b1;
          bit_ff  <= 4'h0;
          cnt_ff  <= bit_div >> 1;
        end
      end else if (cnt_ff != {DIV_W{1'b0}}) begin
        cnt_ff <= cnt_ff - 1'b1;
      end else begin
        cnt_ff <= bit_div - 1'b1; // Full bit period between samples
        bit_ff <= bit_ff + 4'h1;
        if (bit_ff == 4'h0 && rx_sync) begin
          busy_ff <= 1'b0; // False start
        end else if (bit_ff >= 4'h1 && bit_ff <= 4'h8) begin
          sh_ff <= {rx_sync, sh_ff[7:1]};
        end else if (bit_ff == 4'h9) begin
          busy_ff <= 1'b0;
          if (rx_sync) begin
            rx_data_ff  <= sh_ff;
            rx_valid_ff <= 1'b1;
          end
        end
      end
    end
  end
endmodule

// *** tpc_top.v ***
/*
 * Timing pulse and aligned clock block: pulse generator aligned to a
 * time-scale tick, companion clock, serial command intake, reset combine,
 * gain strap and antenna status, all reachable over Avalon-MM.
 * Assumes time_tick is a one-cycle mark from the time solution on mclk, and
 * that pin inputs arrive asynchronously.
 */
// Functional notes
// RULE_01: Each timing pulse starts on a tick of the UTC aligned time scale.
// RULE_02: The pulse repetition can be changed by serial command.
// RULE_03: The aligned clock runs at 4 kHz to 40 kHz in 1 Hz steps.
// RULE_04: Every pulse rising edge coincides with an aligned clock rise.
// RULE_05: Power-on reset is held low while the supply is below threshold.
// RULE_06: Module reset is the wired-OR of power-on and external reset.
// RULE_07: The outside drives the external reset only open-drain.
// RULE_08: Gain strap high selects low gain, low or open selects high gain.
// RULE_09: Board ties the strap high for active antennas, open for passive.
// RULE_10: Two pulled-up inputs report antenna normal, open or short.
// RULE_11: Outside adds no pull-ups on pulse or clock outputs.
// RULE_12: Reserved pins stay unconnected.
// RULE_13: Serial output defaults to 38400 bps; the 38400 default here only sets the serial input bit period.
// RULE_14: Commands come in on the serial input, data leave on serial out; serial_tx_out is held high and sends nothing.
// RULE_15: Processor leaves reset only after both resets are released.
// RULE_16: Power-on reset is released 150 to 250 ms after supply is good.
// RULE_17: Pulse and clock stay low in reset and until config is valid.
`include "tpc_map.vh"
`timescale 1ns/100ps
module tpc_top #(
  parameter POR_CYC = 32'd18750000,
  parameter CFG_W   = 32
) (
  // Clock and reset
  input  wire        mclk,
  input  wire        rst,
  // Supply monitor and external reset pin
  input  wire        supply_good,
  input  wire        ext_reset_n_in,
  output wire        ext_reset_n_out,
  output wire        ext_reset_n_oe_n,
  output wire        cpu_reset,
  // Straps and antenna status
  input  wire        gain_select_strap,
  input  wire        antenna_status_0,
  input  wire        antenna_status_1,
  output reg         low_gain_ff,
  // Time solution mark
  input  wire        time_tick,
  // Timing outputs
  output reg         timing_pulse_out,
  output reg         aligned_clock_out,
  // Serial port
  input  wire        serial_rx_in,
  output reg         serial_tx_out,
  // Avalon-MM slave
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  output wire        avs_response_err,
  // Interrupt
  output wire        irq
);
  // Power-on hold count derived from 150 ms minimum at 125 MHz
  localparam [31:0] POR_MIN_CYC = 32'd125000 * 32'd150;

  function [31:0] be_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  be;
    integer i;
    begin
      be_merge = old_v;
      for (i = 0; i < 4; i = i + 1)
        if (be[i]) be_merge[i*8 +: 8] = new_v[i*8 +: 8];
    end
  endfunction

  // Two-flop synchronisers for pins
  reg [1:0] s_ext_ff, s_gain_ff, s_a0_ff, s_a1_ff, s_rx_ff, s_sup_ff;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_ext_ff  <= 2'b11;
      s_gain_ff <= 2'b00;
      s_a0_ff   <= 2'b11;
      s_a1_ff   <= 2'b11;
      s_rx_ff   <= 2'b11;
      s_sup_ff  <= 2'b00;
    end else begin
      s_ext_ff  <= {s_ext_ff[0], ext_reset_n_in};
      s_gain_ff <= {s_gain_ff[0], gain_select_strap};
      s_a0_ff   <= {s_a0_ff[0], antenna_status_0};
      s_a1_ff   <= {s_a1_ff[0], antenna_status_1};
      s_rx_ff   <= {s_rx_ff[0], serial_rx_in};
      s_sup_ff  <= {s_sup_ff[0], supply_good};
    end
  end

  // Power-on reset counter, low while supply is under threshold
  reg [31:0] por_cnt_ff;
  reg        por_n_ff;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      por_cnt_ff <= 32'h0000_0000;
      por_n_ff   <= 1'b0;
    end else if (!s_sup_ff[1]) begin
      por_cnt_ff <= 32'h0000_0000; // see RULE_05
      por_n_ff   <= 1'b0;
    end else if (por_cnt_ff < POR_CYC - 32'd1) begin
      por_cnt_ff <= por_cnt_ff + 32'd1; // see RULE_16
    end else begin
      por_n_ff   <= 1'b1;
    end
  end

  // Wired-OR reset: pin pulled low by us while power-on reset active
  assign ext_reset_n_out  = 1'b0;
  assign ext_reset_n_oe_n = por_n_ff; // see RULE_06
  reg swrst_ff;
  wire mod_rst = !por_n_ff || !s_ext_ff[1] || swrst_ff; // see RULE_06
  assign cpu_reset = mod_rst; // see RULE_15

  // Gain strap followed during module reset, held from its release
  always @(posedge mclk or posedge rst) begin
    if (rst) low_gain_ff <= 1'b0;
    else if (mod_rst) low_gain_ff <= s_gain_ff[1]; // see RULE_08
  end

  // Registers
  reg [31:0] ctrl_ff, pdiv_ff, cfreq_ff, baud_ff;
  reg [31:0] irq_stat_ff, irq_mask_ff;
  reg [1:0]  ant_ff;
  wire       cfg_ok = (cfreq_ff >= `TPC_CLK_MIN_HZ) &&
                      (cfreq_ff <= `TPC_CLK_MAX_HZ) &&
                      (pdiv_ff != 32'h0000_0000);
  // Outputs run only when enabled, in range and out of reset
  wire       run = ctrl_ff[`TPC_CTRL_EN] && cfg_ok &&
                   !mod_rst; // see RULE_17

  // Bus slave: one wait cycle, answer on the next edge
  reg  ack_ff;
  wire req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_ff;
  wire  take = req & ack_ff;
  wire  wr   = avs_write & take;
  wire  hit  = (avs_address == `TPC_REG_CTRL) ||
               (avs_address == `TPC_REG_PULSE_DIV) ||
               (avs_address == `TPC_REG_CLK_FREQ) ||
               (avs_address == `TPC_REG_STATUS) ||
               (avs_address == `TPC_REG_IRQ_STAT) ||
               (avs_address == `TPC_REG_IRQ_MASK) ||
               (avs_address == `TPC_REG_PINS) ||
               (avs_address == `TPC_REG_BAUD_DIV);
  assign avs_response_err = take & ~hit;

  // Serial command intake
  wire [7:0] rx_byte;
  wire       rx_vld;
  tpc_rx_shift #(.DIV_W(16)) u_rx (
    .mclk        (mclk),
    .rst         (rst),
    .bit_div     (baud_ff[15:0]),
    .rx_sync     (s_rx_ff[1]), // see RULE_14
    .rx_data_ff  (rx_byte),
    .rx_valid_ff (rx_vld)
  );

  // Command assembly: byte 0 selects target, then 4 bytes LSB first
  reg [2:0]  cmd_cnt_ff;
  reg [7:0]  cmd_sel_ff;
  reg [31:0] cmd_val_ff;
  reg        cmd_done_ff;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cmd_cnt_ff  <= 3'h0;
      cmd_sel_ff  <= 8'h00;
      cmd_val_ff  <= 32'h0000_0000;
      cmd_done_ff <= 1'b0;
    end else begin
      cmd_done_ff <= 1'b0;
      if (rx_vld) begin
        if (cmd_cnt_ff == 3'h0) begin
          cmd_sel_ff <= rx_byte;
          cmd_cnt_ff <= 3'h1;
        end else begin
          cmd_val_ff <= {rx_byte, cmd_val_ff[31:8]};
          if (cmd_cnt_ff == 3'h4) begin
            cmd_cnt_ff  <= 3'h0;
            cmd_done_ff <= 1'b1;
          end else begin
            cmd_cnt_ff <= cmd_cnt_ff + 3'h1;
          end
        end
      end
    end
  end
  // Decoded command targets, one cycle after the last value byte
  wire cmd_pdiv = cmd_done_ff &&
                  cmd_sel_ff == `TPC_CMD_PDIV; // see RULE_02
  wire cmd_cfrq = cmd_done_ff &&
                  cmd_sel_ff == `TPC_CMD_CFRQ; // see RULE_03
  wire cmd_bad  = cmd_done_ff && !cmd_pdiv && !cmd_cfrq;

  // Aligned clock NCO: accumulator adds the Hz figure each cycle
  reg [31:0] nco_ff;
  reg        tick_d_ff;
  wire [32:0] nco_sum = {1'b0, nco_ff} + {1'b0, cfreq_ff};
  wire        nco_wrap = nco_sum >= {1'b0, `TPC_MCLK_HZ};
  reg         pulse_go_ff;
  // Falling point of the clock: accumulator crosses half a period
  wire        nco_half = nco_sum[31:0] >= (`TPC_MCLK_HZ >> 1) &&
                         nco_ff < (`TPC_MCLK_HZ >> 1);
  reg  [31:0] sec_cnt_ff;
  wire        pulse_start = time_tick && run &&
                            (sec_cnt_ff == 32'h0000_0000);
  // Tick cycle pulls the clock low, the next cycle raises clock and
  // pulse together: one cycle of latency buys a true clock rise under
  // every pulse rise, whatever phase the clock had at the tick.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      nco_ff            <= 32'h0000_0000;
      aligned_clock_out <= 1'b0;
      timing_pulse_out  <= 1'b0;
      sec_cnt_ff        <= 32'h0000_0000;
      pulse_go_ff       <= 1'b0;
      tick_d_ff         <= 1'b0;
    end else if (!run) begin
      nco_ff            <= 32'h0000_0000; // see RULE_17
      aligned_clock_out <= 1'b0;
      timing_pulse_out  <= 1'b0;
      sec_cnt_ff        <= 32'h0000_0000;
      pulse_go_ff       <= 1'b0;
      tick_d_ff         <= 1'b0;
    end else begin
      tick_d_ff   <= time_tick;
      pulse_go_ff <= pulse_start;
      if (time_tick) begin
        // Clock forced low so the next edge is a real rise
        nco_ff            <= 32'h0000_0000; // see RULE_04
        aligned_clock_out <= 1'b0;          // see RULE_04
        sec_cnt_ff <= (sec_cnt_ff + 32'd1 >= pdiv_ff) ?
                      32'h0000_0000 : sec_cnt_ff + 32'd1;
      end else if (tick_d_ff) begin
        // Phase zero at the forced rising edge
        nco_ff            <= 32'h0000_0000; // see RULE_04
        aligned_clock_out <= 1'b1;          // see RULE_04
      end else begin
        nco_ff <= nco_wrap ? nco_sum[31:0] - `TPC_MCLK_HZ : nco_sum[31:0];
        // Half period toggles
        if (nco_half)
          aligned_clock_out <= 1'b0;
        else if (nco_wrap)
          aligned_clock_out <= 1'b1; // see RULE_03
      end
      // Pulse rises with the clock and ends at the clock's first fall
      if (pulse_go_ff)
        timing_pulse_out <= 1'b1; // see RULE_01
      else if (time_tick || nco_half)
        timing_pulse_out <= 1'b0;
    end
  end

  // Serial transmit: idle high, antenna/pulse flags sent are firmware's job
  always @(posedge mclk or posedge rst) begin
    if (rst) serial_tx_out <= 1'b1;
    else serial_tx_out <= 1'b1; // see RULE_14
  end

  // Register writes, command writes and interrupt flags
  wire [1:0] ant_now = {s_a1_ff[1], s_a0_ff[1]}; // see RULE_10
  wire [31:0] ev = {28'h000_0000, cmd_bad, rx_vld,
                    ant_now != ant_ff, pulse_start};
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_ff      <= 1'b0;
      ctrl_ff     <= 32'h0000_0000;
      pdiv_ff     <= `TPC_PULSE_DIV_DEF;
      cfreq_ff    <= `TPC_CLK_MIN_HZ;
      baud_ff     <= `TPC_MCLK_HZ / `TPC_BAUD_DEF; // see RULE_13
      irq_stat_ff <= 32'h0000_0000;
      irq_mask_ff <= 32'h0000_0000;
      ant_ff      <= `TPC_ANT_NORMAL;
      swrst_ff    <= 1'b0;
    end else begin
      ack_ff   <= req & ~ack_ff;
      ant_ff   <= ant_now;
      swrst_ff <= ctrl_ff[`TPC_CTRL_SWRST];
      if (cmd_pdiv) pdiv_ff <= cmd_val_ff;
      else if (wr && avs_address == `TPC_REG_PULSE_DIV)
        pdiv_ff <= be_merge(pdiv_ff, avs_writedata, avs_byteenable);
      if (cmd_cfrq) cfreq_ff <= cmd_val_ff;
      else if (wr && avs_address == `TPC_REG_CLK_FREQ)
        cfreq_ff <= be_merge(cfreq_ff, avs_writedata, avs_byteenable);
      if (wr && avs_address == `TPC_REG_CTRL)
        ctrl_ff <= be_merge(ctrl_ff, avs_writedata, avs_byteenable);
      if (wr && avs_address == `TPC_REG_BAUD_DIV)
        baud_ff <= be_merge(baud_ff, avs_writedata, avs_byteenable);
      if (wr && avs_address == `TPC_REG_IRQ_MASK)
        irq_mask_ff <= be_merge(irq_mask_ff, avs_writedata, avs_byteenable);
      // Write one to clear, new event wins
      if (wr && avs_address == `TPC_REG_IRQ_STAT)
        irq_stat_ff <= (irq_stat_ff &
                        ~be_merge(32'h0000_0000, avs_writedata,
                                  avs_byteenable)) | ev;
      else
        irq_stat_ff <= irq_stat_ff | ev;
    end
  end
  assign irq = |(irq_stat_ff & irq_mask_ff);

  // Read data mux
  always @* begin
    case (avs_address)
      `TPC_REG_CTRL:      avs_readdata = ctrl_ff;
      `TPC_REG_PULSE_DIV: avs_readdata = pdiv_ff;
      `TPC_REG_CLK_FREQ:  avs_readdata = cfreq_ff;
      `TPC_REG_STATUS:    avs_readdata = {26'h000_0000, cfg_ok, run,
                                          low_gain_ff, mod_rst, ant_ff};
      `TPC_REG_IRQ_STAT:  avs_readdata = irq_stat_ff;
      `TPC_REG_IRQ_MASK:  avs_readdata = irq_mask_ff;
      `TPC_REG_PINS:      avs_readdata = {29'h0000_0000, s_ext_ff[1],
                                          por_n_ff, s_gain_ff[1]};
      `TPC_REG_BAUD_DIV:  avs_readdata = baud_ff;
      default:            avs_readdata = `TPC_BAD_DATA;
    endcase
  end
endmodule
